// ### dac_latch_host_pkg.sv
// Package for the converter latch host controller.
// Holds pin bundle type, load modes, states and strobe timing counts.
package dac_latch_host_pkg;
  localparam int DATA_W = 12;
  localparam int NIBBLE_LSB = 8;
  localparam int BYTE_MSB = 7;
  localparam logic [11:0] BIPOLAR_ZERO = 12'h800;
  localparam int CLK_NS = 20;
  // Least setup before strobe, strobe width and hold after strobe, in ns
  localparam int SETUP_NS = 60;
  localparam int STROBE_NS = 100;
  localparam int HOLD_NS = 20;
  localparam int RESET_NS = 200;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;

  // Load modes requested by the user side
  typedef enum logic [2:0] {
    MODE_HIGH_NIBBLE = 3'h0,
    MODE_LOW_BYTE = 3'h1,
    MODE_LOAD_OUT = 3'h2,
    MODE_TRANSPARENT = 3'h3,
    MODE_RESET = 3'h4
  } load_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_STROBE = 5'h04,
    ST_HOLD = 5'h08,
    ST_RESET = 5'h10
  } host_state_e;

  // Pins driven into the converter, all active low controls
  typedef struct packed {
    logic strobe_n;
    logic output_load_n;
    logic high_nibble_enable_n;
    logic low_byte_enable_n;
    logic reset_n;
    logic [11:0] data;
  } dac_pins_s;
endpackage

// ### dac_latch_host.sv
// Host-side controller driving a double-buffered 12-bit converter latch.
// Assumes converter pins are wired straight to outputs, one 50 MHz clock.
//
// Operation
// - Every latch write is performed with the master strobe held low, and the strobe idles high.
// - A load of the converter latch drives output load low together with the master strobe.
// - The high nibble enable with the strobe loads data bits eight to eleven into a 4-bit latch.
// - The low byte enable with the strobe loads data bits zero to seven into an 8-bit latch.
`timescale 1ns/10ps
module dac_latch_host
  import dac_latch_host_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire load_mode_e REQ_MODE,
  input wire logic [11:0] REQ_DATA,
  output logic REQ_READY,
  output logic DONE,
  output logic [11:0] SHADOW_WORD,
  output dac_pins_s PINS
);

  host_state_e state;
  host_state_e next_state;
  load_mode_e mode;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [11:0] hold_data;
  logic [3:0] nib_shadow;
  logic [7:0] byte_shadow;
  logic [11:0] out_shadow;
  dac_pins_s next_pins;

  // State decode
  wire in_idle = (state == ST_IDLE);
  wire in_setup = (state == ST_SETUP);
  wire in_strobe = (state == ST_STROBE);
  wire in_hold = (state == ST_HOLD);
  wire in_reset = (state == ST_RESET);
  wire in_cycle = in_setup || in_strobe || in_hold;
  wire cnt_done = (cnt == '0);

  // Request acceptance, only while idle
  wire take = in_idle && REQ_VALID;
  wire go_reset = take && (REQ_MODE == MODE_RESET);
  wire go_write = take && (REQ_MODE != MODE_RESET);

  // Latches the incoming request opens
  wire req_nib = (REQ_MODE == MODE_HIGH_NIBBLE) || (REQ_MODE == MODE_TRANSPARENT);
  wire req_byte = (REQ_MODE == MODE_LOW_BYTE) || (REQ_MODE == MODE_TRANSPARENT);
  wire req_out = (REQ_MODE == MODE_LOAD_OUT) || (REQ_MODE == MODE_TRANSPARENT);

  // Latches the held request opens
  wire sel_nib = (mode == MODE_HIGH_NIBBLE) || (mode == MODE_TRANSPARENT);
  wire sel_byte = (mode == MODE_LOW_BYTE) || (mode == MODE_TRANSPARENT);
  wire sel_out = (mode == MODE_LOAD_OUT) || (mode == MODE_TRANSPARENT);
  wire sel_pass = (mode == MODE_TRANSPARENT);

  // Phase ends, each when its counter has run down
  wire setup_end = in_setup && cnt_done;
  wire strobe_end = in_strobe && cnt_done;
  wire hold_end = in_hold && cnt_done;
  wire reset_end = in_reset && cnt_done;
  wire finish = hold_end || reset_end;

  // Next state sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (go_reset) begin
          next_state = ST_RESET;
        end else if (go_write) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (setup_end) next_state = ST_STROBE;
      end
      ST_STROBE: begin
        if (strobe_end) next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (hold_end) next_state = ST_IDLE;
      end
      ST_RESET: begin
        if (reset_end) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Enables go low on the take and rise only after the hold phase
  wire stay = in_cycle && (next_state != ST_IDLE);
  wire nib_on = take ? req_nib : (stay && sel_nib);
  wire byte_on = take ? req_byte : (stay && sel_byte);
  wire out_on = take ? req_out : (stay && sel_out);

  // Pin values: enables set during setup, strobe only in strobe phase
  always_comb begin
    next_pins.strobe_n = ~(next_state == ST_STROBE);
    next_pins.output_load_n = ~out_on;
    next_pins.high_nibble_enable_n = ~nib_on;
    next_pins.low_byte_enable_n = ~byte_on;
    next_pins.reset_n = ~(next_state == ST_RESET);
    next_pins.data = take ? REQ_DATA : hold_data;
  end

  // Counter: reload on a phase change, else run down to zero
  always_comb begin
    next_cnt = cnt;
    if (next_state != state) begin
      case (next_state)
        ST_SETUP: next_cnt = CNT_W'(SETUP_CYC - 1);
        ST_STROBE: next_cnt = CNT_W'(STROBE_CYC - 1);
        ST_HOLD: next_cnt = CNT_W'(HOLD_CYC - 1);
        ST_RESET: next_cnt = CNT_W'(RESET_CYC - 1);
        default: next_cnt = '0;
      endcase
    end else if (!cnt_done) begin
      next_cnt = cnt - 1'b1;
    end
  end

  // Sequencer state and phase counter
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Captured request, kept until the next take
  always_ff @(posedge CLK) begin
    if (RST) begin
      mode <= MODE_HIGH_NIBBLE;
      hold_data <= '0;
    end else if (take) begin
      mode <= REQ_MODE;
      hold_data <= REQ_DATA;
    end
  end

  // Registered pins
  always_ff @(posedge CLK) begin
    if (RST) begin
      PINS <= '{strobe_n: 1'b1, output_load_n: 1'b1, high_nibble_enable_n: 1'b1,
               low_byte_enable_n: 1'b1, reset_n: 1'b0, data: 12'h000};
    end else begin
      PINS <= next_pins;
    end
  end

  // Shadow of the device latches, updated as the strobe closes
  wire [11:0] word_assembled = {nib_shadow, byte_shadow};
  wire [11:0] load_word = sel_pass ? hold_data : word_assembled;
  wire [3:0] next_nib = (strobe_end && sel_nib) ? hold_data[DATA_W-1:NIBBLE_LSB] : nib_shadow;
  wire [7:0] next_byte = (strobe_end && sel_byte) ? hold_data[BYTE_MSB:0] : byte_shadow;
  wire [11:0] next_out = in_reset ? BIPOLAR_ZERO : ((strobe_end && sel_out) ? load_word : out_shadow);

  // High nibble shadow
  always_ff @(posedge CLK) begin
    if (RST) begin
      nib_shadow <= '0;
    end else begin
      nib_shadow <= next_nib;
    end
  end

  // Low byte shadow
  always_ff @(posedge CLK) begin
    if (RST) begin
      byte_shadow <= '0;
    end else begin
      byte_shadow <= next_byte;
    end
  end

  // Converter latch shadow, bipolar zero after either reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_shadow <= BIPOLAR_ZERO;
    end else begin
      out_shadow <= next_out;
    end
  end

  // Handshake next values
  wire next_ready = (next_state == ST_IDLE);
  wire next_done = finish;
  wire [11:0] next_shadow_word = out_shadow;

  // Ready whenever the sequencer returns to idle
  always_ff @(posedge CLK) begin
    if (RST) begin
      REQ_READY <= 1'b0;
    end else begin
      REQ_READY <= next_ready;
    end
  end

  // One-cycle completion pulse
  always_ff @(posedge CLK) begin
    if (RST) begin
      DONE <= 1'b0;
    end else begin
      DONE <= next_done;
    end
  end

  // Converter word as the user side sees it
  always_ff @(posedge CLK) begin
    if (RST) begin
      SHADOW_WORD <= BIPOLAR_ZERO;
    end else begin
      SHADOW_WORD <= next_shadow_word;
    end
  end

endmodule

// ### dac_latch_host_asserts.sv
// Assertions on the latch host controller pins.
// Bound into every controller instance.
`timescale 1ns/10ps
module dac_latch_host_asserts
  import dac_latch_host_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire load_mode_e REQ_MODE,
  input wire logic [11:0] REQ_DATA,
  input wire logic REQ_READY,
  input wire dac_pins_s PINS
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Taken request and strobe pulse
  sequence take_s(load_mode_e m);
    REQ_VALID && REQ_READY && REQ_MODE == m;
  endsequence
  sequence pulse_s;
    !PINS.strobe_n [*5] ##1 PINS.strobe_n;
  endsequence
  width_a: assert property ($fell(PINS.strobe_n) |-> pulse_s) else $error("strobe width");
  load_a: assert property (take_s(MODE_LOAD_OUT) |-> ##4 !PINS.output_load_n && !PINS.strobe_n)
    else $error("load");
  nibble_a: assert property (take_s(MODE_HIGH_NIBBLE) |=> !PINS.high_nibble_enable_n
    && PINS.low_byte_enable_n && PINS.data[11:8] == $past(REQ_DATA[11:8])) else $error("nibble");
  byte_a: assert property (take_s(MODE_LOW_BYTE) |=> !PINS.low_byte_enable_n
    && PINS.high_nibble_enable_n && PINS.data[7:0] == $past(REQ_DATA[7:0])) else $error("byte");
  all_a: assert property (take_s(MODE_TRANSPARENT) |-> ##4 !(PINS.output_load_n |
    PINS.high_nibble_enable_n | PINS.low_byte_enable_n | PINS.strobe_n)) else $error("all");
  hold_a: assert property (!PINS.strobe_n |=> $stable(PINS.data)) else $error("hold");
  quiet_a: assert property (!PINS.reset_n |-> PINS.strobe_n) else $error("quiet");
  rst_a: assert property (take_s(MODE_RESET) |-> ##[1:3] !PINS.reset_n) else $error("reset");
  // Enables held steady across both strobe edges
  sequence ctl_steady_s;
    $stable({PINS.output_load_n, PINS.high_nibble_enable_n, PINS.low_byte_enable_n});
  endsequence
  settle_a: assert property ($fell(PINS.strobe_n) |-> ctl_steady_s) else $error("enables move at fall");
  release_a: assert property ($rose(PINS.strobe_n) |-> ctl_steady_s) else $error("enables move at rise");
endmodule
bind dac_latch_host dac_latch_host_asserts u_dac_latch_host_asserts (.CLK, .RST, .REQ_VALID,
  .REQ_MODE, .REQ_DATA, .REQ_READY, .PINS);

// ### dac_latch_model.sv
// Behavioural converter device with its three latches.
// Fed straight from the controller pins.
`timescale 1ns/10ps
module dac_latch_model
  import dac_latch_host_pkg::*;
(
  input wire dac_pins_s PINS,
  output logic [11:0] DAC_WORD
);
  logic [3:0] nib;
  logic [7:0] low;
  // Input latches, open only with strobe low
  always_latch begin
    if (!PINS.strobe_n && !PINS.high_nibble_enable_n) nib <= PINS.data[11:8];
    if (!PINS.strobe_n && !PINS.low_byte_enable_n) low <= PINS.data[7:0];
  end
  // Converter latch, reset wins
  always_latch begin
    if (!PINS.reset_n) DAC_WORD <= BIPOLAR_ZERO;
    else if (!PINS.strobe_n && !PINS.output_load_n) DAC_WORD <= {nib, low};
  end
endmodule

// ### tb.sv
// Self-checking bench: controller driving the device model.
// Inputs change at falling clock edges.
`timescale 1ns/10ps
module tb;
  import dac_latch_host_pkg::*;
  logic CLK, RST, REQ_VALID, REQ_READY, DONE;
  load_mode_e REQ_MODE;
  logic [11:0] REQ_DATA, SHADOW_WORD, word;
  dac_pins_s PINS;
  int num_errors = 0, total_checks = 0, cycles = 0;
  dac_latch_host u_dac_latch_host (.CLK, .RST, .REQ_VALID, .REQ_MODE, .REQ_DATA, .REQ_READY, .DONE,
    .SHADOW_WORD, .PINS);
  dac_latch_model u_dac_latch_model (.PINS, .DAC_WORD(word));
  // Clock and hang guard
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // Compare and count
  task chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One request, wait for its completion
  task send(input load_mode_e m, input logic [11:0] d);
    int n;
    n = 0;
    while (REQ_READY !== 1'b1) @(negedge CLK);
    REQ_VALID = 1;
    REQ_MODE = m;
    REQ_DATA = d;
    @(negedge CLK);
    REQ_VALID = 0;
    chk({11'h000, REQ_READY}, 12'h000);
    while (DONE !== 1'b1 && n < 30) begin
      @(negedge CLK);
      n++;
    end
    chk({11'h000, DONE}, 12'h001);
    chk(12'(n), (m == MODE_RESET) ? 12'(RESET_CYC) : 12'(SETUP_CYC + STROBE_CYC + HOLD_CYC));
    chk({11'h000, REQ_READY}, 12'h001);
    @(negedge CLK);
    chk({11'h000, DONE}, 12'h000);
  endtask
  task test_split;
    chk(word, BIPOLAR_ZERO);
    send(MODE_HIGH_NIBBLE, 12'ha00);
    send(MODE_LOW_BYTE, 12'h05c);
    chk(word, BIPOLAR_ZERO);
    send(MODE_LOAD_OUT, 12'h000);
    chk(word, 12'ha5c);
    chk(SHADOW_WORD, 12'ha5c);
    $display("test split done");
  endtask
  task test_pass;
    send(MODE_TRANSPARENT, 12'h3c7);
    chk(word, 12'h3c7);
    chk(SHADOW_WORD, 12'h3c7);
    $display("test pass done");
  endtask
  task test_reset;
    send(MODE_HIGH_NIBBLE, 12'hf00);
    send(MODE_RESET, 12'h123);
    chk(word, BIPOLAR_ZERO);
    chk(SHADOW_WORD, BIPOLAR_ZERO);
    send(MODE_LOAD_OUT, 12'h000);
    chk(word, 12'hfc7);
    chk(SHADOW_WORD, 12'hfc7);
    $display("test reset done");
  endtask
  task test_restart;
    send(MODE_TRANSPARENT, 12'h5a1);
    chk(word, 12'h5a1);
    RST = 1;
    repeat (2) @(negedge CLK);
    chk(word, BIPOLAR_ZERO);
    RST = 0;
    @(negedge CLK);
    chk({11'h000, REQ_READY}, 12'h001);
    chk(SHADOW_WORD, BIPOLAR_ZERO);
    chk(word, BIPOLAR_ZERO);
    $display("test restart done");
  endtask
  // Main sequence
  initial begin
    RST = 1;
    REQ_VALID = 0;
    REQ_MODE = MODE_HIGH_NIBBLE;
    REQ_DATA = 12'h000;
    repeat (16) @(negedge CLK);
    RST = 0;
    @(negedge CLK);
    test_split();
    test_pass();
    test_reset();
    test_restart();
    report_and_stop();
  end
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
endmodule
